// ===== core/piet_cfg.svh
// Register map, field positions, vector and count constants and timing figures
`ifndef PIET_CFG_SVH
`define PIET_CFG_SVH
`define PIET_REG_SRC     4'h0
`define PIET_REG_CH      4'h1
`define PIET_CH_CTRL     4'h0
`define PIET_CH_SRCP     4'h4
`define PIET_CH_DSTP     4'h8
`define PIET_EDGE_OFS    12'h200
`define PIET_STAT_OFS    12'h204
`define PIET_CLR_OFS     12'h208
`define PIET_IEN_OFS     12'h20C
`define PIET_LVL_LSB     0
`define PIET_CHS_LSB     4
`define PIET_ENG_BIT     7
`define PIET_EN_BIT      8
`define PIET_REQ_BIT     9
`define PIET_CNT_LSB     0
`define PIET_WORD_BIT    8
`define PIET_INCD_BIT    9
`define PIET_CONT_BIT    10
`define PIET_EV_VEC      0
`define PIET_EV_XFER     1
`define PIET_EV_DONE     2
`define PIET_EV_W        3
`define PIET_FAST0_TRAP  8'h18
`define PIET_TRAP_LVL    4'hF
`define PIET_CNT_ONE     8'h01
`define PIET_CNT_ZERO    8'h00
`define PIET_RESP_MAX    12
`endif

// ===== core/piet_pkg.sv
// Types shared by the interrupt controller and its edge detector
`default_nettype none
package piet_pkg;
  typedef enum logic [0:0] {VS_IDLE = 1'b0, VS_OFFER = 1'b1} piet_vst_t;
  typedef enum logic [1:0] {EM_OFF = 2'b00, EM_RISE = 2'b01, EM_FALL = 2'b10,
                            EM_BOTH = 2'b11} piet_edge_t;
endpackage : piet_pkg
`default_nettype wire

// ===== core/piet_edge.sv
// Edge detector for the fast external request inputs
`default_nettype none
module piet_edge #(
  parameter int NFAST = 4
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [NFAST-1:0]   pin,
  input  wire logic [2*NFAST-1:0] mode,
  output logic      [NFAST-1:0]   hit
);
  import piet_pkg::*;
  logic [NFAST-1:0] prev_q;
  logic             armed_q;

  // Armed only after one sample, so a pin high at reset is no edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_q  <= '0;
      armed_q <= 1'b0;
    end
    else
    begin
      prev_q  <= pin;
      armed_q <= 1'b1;
    end
  end

  for (genvar g = 0; g < NFAST; g++)
  begin : g_edge
    always_comb
    begin
      case (piet_edge_t'(mode[2*g +: 2]))
        EM_RISE: hit[g] = armed_q & pin[g] & ~prev_q[g];
        EM_FALL: hit[g] = armed_q & ~pin[g] & prev_q[g];
        EM_BOTH: hit[g] = armed_q & (pin[g] ^ prev_q[g]);
        default: hit[g] = 1'b0;
      endcase
    end
  end

  a_edge_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (armed_q && mode[1:0] == EM_RISE && pin[0] && !prev_q[0]) |-> hit[0])
    else $error("rising edge on input 0 not detected");
endmodule : piet_edge
`default_nettype wire

// ===== core/piet_ctrl.sv
// Prioritised interrupt controller with event transfer engine
`include "piet_cfg.svh"
`default_nettype none
module piet_ctrl #(
  parameter int NSRC  = 8,
  parameter int NCH   = 8,
  parameter int NFAST = 4,
  parameter int AW    = 24
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [NFAST-1:0] fast_pin,
  input  wire logic [NSRC-1:0]  hw_req,
  input  wire logic [3:0]  cpu_level,
  input  wire logic        cpu_ack,
  input  wire logic        trap_valid,
  input  wire logic [7:0]  trap_num,
  output logic             vec_req,
  output logic [AW-1:0]    vec_addr,
  output logic [3:0]       vec_level,
  output logic             vec_trap,
  output logic             mv_valid,
  output logic [AW-1:0]    mv_src,
  output logic [AW-1:0]    mv_dst,
  output logic             mv_word,
  output logic             irq
);
  import piet_pkg::*;
  localparam int SW = $clog2(NSRC);
  localparam int CW = $clog2(NCH);
  localparam int RESP_MAX = `PIET_RESP_MAX;

  function automatic logic [7:0] trap_of(input logic [SW-1:0] i);
    return `PIET_FAST0_TRAP + 8'(i);
  endfunction : trap_of
  function automatic logic [AW-1:0] vec_of(input logic [7:0] t);
    return AW'({t, 2'b00});
  endfunction : vec_of
  function automatic logic src_hit(input logic [11:0] a);
    return a[11:8] == `PIET_REG_SRC && 32'(a[7:2]) < NSRC && a[1:0] == 2'b00;
  endfunction : src_hit
  function automatic logic ch_hit(input logic [11:0] a);
    return a[11:8] == `PIET_REG_CH && 32'(a[7:4]) < NCH &&
           (a[3:0] == `PIET_CH_CTRL || a[3:0] == `PIET_CH_SRCP || a[3:0] == `PIET_CH_DSTP);
  endfunction : ch_hit
  function automatic logic misc_hit(input logic [11:0] a);
    return a == `PIET_EDGE_OFS || a == `PIET_STAT_OFS || a == `PIET_CLR_OFS ||
           a == `PIET_IEN_OFS;
  endfunction : misc_hit

  logic [3:0]    lvl_q  [NSRC];
  logic [CW-1:0] chs_q  [NSRC];
  logic [NSRC-1:0] eng_q, en_q, req_q, force_q, set_v, clr_v, done_set, req_in;
  logic [AW-1:0] ch_src_q [NCH];
  logic [AW-1:0] ch_dst_q [NCH];
  logic [7:0]    ch_cnt_q [NCH];
  logic [NCH-1:0] ch_word_q, ch_incd_q, ch_cont_q;
  logic [2*NFAST-1:0] edge_cfg_q;
  logic [NFAST-1:0]   fast_hit;
  logic [`PIET_EV_W-1:0] stat_q, ien_q, ev;
  logic [31:0]   rd_d;
  logic          pready_q, pslverr_q, wr_en, rd_go, irq_q;
  logic [31:0]   prdata_q;
  logic [SW-1:0] sidx, win_idx, vec_src_q;
  logic [CW-1:0] cidx, win_ch, mv_ch_q;
  logic [3:0]    win_lvl, vec_level_q;
  logic          win_valid, win_eng, eng_fire, vec_ack;
  piet_vst_t     st_q;
  logic          vec_req_q, vec_trap_q, trap_pend_q, wr_ch_any;
  logic [7:0]    trap_num_q, mv_cnt_q;
  logic [AW-1:0] vec_addr_q, mv_src_q, mv_dst_q;
  logic          mv_valid_q, mv_word_q, mv_cont_q;
  logic [SW-1:0] mv_sidx_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign vec_req = vec_req_q;
  assign vec_addr = vec_addr_q;
  assign vec_level = vec_level_q;
  assign vec_trap = vec_trap_q;
  assign mv_valid = mv_valid_q;
  assign mv_src = mv_src_q;
  assign mv_dst = mv_dst_q;
  assign mv_word = mv_word_q;
  assign irq = irq_q;

  piet_edge #(.NFAST(NFAST)) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (fast_pin),
    .mode    (edge_cfg_q),
    .hit     (fast_hit)
  );
  assign req_in = hw_req | NSRC'(fast_hit);

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, writes land on the pready edge
  assign sidx = paddr[SW+1:2];
  assign cidx = paddr[CW+3:4];
  assign rd_go = psel & penable & ~pready_q;
  assign wr_en = psel & penable & pready_q & pwrite;
  assign wr_ch_any = wr_en & ch_hit(paddr);

  always_comb
  begin
    rd_d = '0;
    if (src_hit(paddr))
    begin
      rd_d[`PIET_LVL_LSB +: 4]  = lvl_q[sidx];
      rd_d[`PIET_CHS_LSB +: CW] = chs_q[sidx];
      rd_d[`PIET_ENG_BIT]       = eng_q[sidx];
      rd_d[`PIET_EN_BIT]        = en_q[sidx];
      rd_d[`PIET_REQ_BIT]       = req_q[sidx];
    end
    else if (ch_hit(paddr))
    begin
      case (paddr[3:0])
        `PIET_CH_CTRL:
        begin
          rd_d[`PIET_CNT_LSB +: 8] = ch_cnt_q[cidx];
          rd_d[`PIET_WORD_BIT]     = ch_word_q[cidx];
          rd_d[`PIET_INCD_BIT]     = ch_incd_q[cidx];
          rd_d[`PIET_CONT_BIT]     = ch_cont_q[cidx];
        end
        `PIET_CH_SRCP: rd_d[AW-1:0] = ch_src_q[cidx];
        default:       rd_d[AW-1:0] = ch_dst_q[cidx];
      endcase
    end
    else if (paddr == `PIET_EDGE_OFS)
      rd_d[2*NFAST-1:0] = edge_cfg_q;
    else if (paddr == `PIET_STAT_OFS)
      rd_d[`PIET_EV_W-1:0] = stat_q;
    else if (paddr == `PIET_IEN_OFS)
      rd_d[`PIET_EV_W-1:0] = ien_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= rd_go;
      pslverr_q <= rd_go & ~(src_hit(paddr) | ch_hit(paddr) | misc_hit(paddr));
      prdata_q  <= (rd_go & ~pwrite) ? rd_d : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Arbitration
  always_comb
  begin
    win_valid = 1'b0;
    win_idx   = '0;
    win_lvl   = '0;
    for (int i = 0; i < NSRC; i++)
    begin
      // level beats running level; ties keep lowest index
      if (req_q[i] && en_q[i] && lvl_q[i] > cpu_level && (!win_valid || lvl_q[i] > win_lvl))
      begin
        win_valid = 1'b1;
        win_idx   = SW'(i);
        win_lvl   = lvl_q[i];
      end
    end
  end

  assign win_ch = chs_q[win_idx];
  // engine path unless exhausted or a completion is owed
  assign win_eng = eng_q[win_idx] & ~force_q[win_idx] & (ch_cnt_q[win_ch] != `PIET_CNT_ZERO);
  assign eng_fire = win_valid & win_eng;
  assign vec_ack = (st_q == VS_OFFER) & cpu_ack;

  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      // last count turns into a vectored request of this source
      done_set[i] = eng_fire && win_idx == SW'(i) && !ch_cont_q[win_ch] &&
                    ch_cnt_q[win_ch] == `PIET_CNT_ONE;
      // software set acts like a hardware event
      set_v[i] = req_in[i] | done_set[i] |
                 (wr_en & src_hit(paddr) & sidx == SW'(i) & pwdata[`PIET_REQ_BIT]);
      clr_v[i] = (vec_ack & ~vec_trap_q & vec_src_q == SW'(i)) |
                 (eng_fire & win_idx == SW'(i)) |
                 (wr_en & src_hit(paddr) & sidx == SW'(i) & ~pwdata[`PIET_REQ_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source control registers; a set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NSRC; i++)
      begin
        lvl_q[i] <= '0;
        chs_q[i] <= '0;
      end
      eng_q   <= '0;
      en_q    <= '0;
      req_q   <= '0;
      force_q <= '0;
    end
    else
    begin
      req_q   <= set_v | (req_q & ~clr_v);
      force_q <= done_set | (force_q & ~clr_v);
      if (wr_en && src_hit(paddr))
      begin
        lvl_q[sidx] <= pwdata[`PIET_LVL_LSB +: 4];
        chs_q[sidx] <= pwdata[`PIET_CHS_LSB +: CW];
        eng_q[sidx] <= pwdata[`PIET_ENG_BIT];
        en_q[sidx]  <= pwdata[`PIET_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer channels; a software write to the firing channel wins
  // independent channel state
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [AW-1:0] inc;
    assign inc = ch_word_q[c] ? AW'(2) : AW'(1);
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ch_src_q[c]  <= '0;
        ch_dst_q[c]  <= '0;
        ch_cnt_q[c]  <= '0;
        ch_word_q[c] <= 1'b0;
        ch_incd_q[c] <= 1'b0;
        ch_cont_q[c] <= 1'b0;
      end
      else if (wr_ch_any && cidx == CW'(c))
      begin
        case (paddr[3:0])
          `PIET_CH_CTRL:
          begin
            ch_cnt_q[c]  <= pwdata[`PIET_CNT_LSB +: 8];
            ch_word_q[c] <= pwdata[`PIET_WORD_BIT];
            ch_incd_q[c] <= pwdata[`PIET_INCD_BIT];
            ch_cont_q[c] <= pwdata[`PIET_CONT_BIT];
          end
          `PIET_CH_SRCP: ch_src_q[c] <= pwdata[AW-1:0];
          default:       ch_dst_q[c] <= pwdata[AW-1:0];
        endcase
      end
      else if (eng_fire && win_ch == CW'(c))
      begin
        // bump exactly one pointer by the item size
        if (ch_incd_q[c])
          ch_dst_q[c] <= ch_dst_q[c] + inc;
        else
          ch_src_q[c] <= ch_src_q[c] + inc;
        if (!ch_cont_q[c])
          ch_cnt_q[c] <= ch_cnt_q[c] - `PIET_CNT_ONE;
      end
    end
  end

  // single-cycle move strobe, the core only stalls for it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mv_valid_q <= 1'b0;
      mv_src_q   <= '0;
      mv_dst_q   <= '0;
      mv_word_q  <= 1'b0;
      mv_ch_q    <= '0;
      mv_cnt_q   <= '0;
      mv_cont_q  <= 1'b0;
      mv_sidx_q  <= '0;
    end
    else
    begin
      mv_valid_q <= eng_fire;
      mv_src_q   <= ch_src_q[win_ch];
      mv_dst_q   <= ch_dst_q[win_ch];
      mv_word_q  <= ch_word_q[win_ch];
      mv_ch_q    <= win_ch;
      mv_cnt_q   <= ch_cnt_q[win_ch];
      mv_cont_q  <= ch_cont_q[win_ch];
      mv_sidx_q  <= win_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Vector offer to the core; offer is frozen until acknowledged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q        <= VS_IDLE;
      vec_req_q   <= 1'b0;
      vec_addr_q  <= '0;
      vec_level_q <= '0;
      vec_trap_q  <= 1'b0;
      vec_src_q   <= '0;
      trap_pend_q <= 1'b0;
      trap_num_q  <= '0;
    end
    else
    begin
      if (trap_valid)
        trap_num_q <= trap_num;
      trap_pend_q <= trap_valid | (trap_pend_q & ~(vec_ack & vec_trap_q));
      case (st_q)
        VS_IDLE:
        begin
          if (trap_pend_q)
          begin
            vec_addr_q  <= vec_of(trap_num_q);
            vec_level_q <= `PIET_TRAP_LVL;
            vec_trap_q  <= 1'b1;
            vec_req_q   <= 1'b1;
            st_q        <= VS_OFFER;
          end
          else if (win_valid && !win_eng)
          begin
            // offer next cycle at the source vector
            vec_addr_q  <= vec_of(trap_of(win_idx));
            vec_level_q <= win_lvl;
            vec_src_q   <= win_idx;
            vec_trap_q  <= 1'b0;
            vec_req_q   <= 1'b1;
            st_q        <= VS_OFFER;
          end
        end
        VS_OFFER:
        begin
          if (cpu_ack)
          begin
            vec_req_q <= 1'b0;
            st_q      <= VS_IDLE;
          end
        end
        default: st_q <= VS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event status, clear and enable; irq follows status one cycle late
  assign ev = {|done_set, eng_fire, vec_ack};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q     <= '0;
      ien_q      <= '0;
      irq_q      <= 1'b0;
      edge_cfg_q <= '0;
    end
    else
    begin
      stat_q <= ev | (stat_q & ~((wr_en && paddr == `PIET_CLR_OFS) ?
                                 pwdata[`PIET_EV_W-1:0] : '0));
      irq_q  <= |(stat_q & ien_q);
      if (wr_en && paddr == `PIET_IEN_OFS)
        ien_q <= pwdata[`PIET_EV_W-1:0];
      if (wr_en && paddr == `PIET_EDGE_OFS)
        edge_cfg_q <= pwdata[2*NFAST-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_vec_loc: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req_q && !vec_trap_q |-> vec_addr_q == vec_of(trap_of(vec_src_q)))
    else $error("source vector location wrong");
  a_trap_loc: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req_q && vec_trap_q |-> vec_addr_q == AW'({trap_num_q, 2'b00}))
    else $error("trap vector location wrong");
  a_resp_first: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == VS_IDLE && !trap_pend_q && win_valid && !win_eng)
    |=> vec_req_q && vec_level_q == $past(win_lvl))
    else $error("vectored request not offered next cycle");
  a_resp_max: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == VS_IDLE && !trap_pend_q && win_valid && !win_eng) |-> ##[1:RESP_MAX] vec_req_q)
    else $error("response window exceeded");
  a_level_high: assert property (@(posedge pclk) disable iff (!presetn)
    win_valid |-> win_lvl > cpu_level && en_q[win_idx])
    else $error("winner does not outrank running level");
  a_xfer_ptr: assert property (@(posedge pclk) disable iff (!presetn)
    mv_valid_q && !$past(wr_ch_any) |-> ch_src_q[mv_ch_q] + ch_dst_q[mv_ch_q] ==
    mv_src_q + mv_dst_q + (mv_word_q ? AW'(2) : AW'(1)))
    else $error("pointer not advanced by item size");
  a_cnt_dec: assert property (@(posedge pclk) disable iff (!presetn)
    mv_valid_q && !$past(wr_ch_any) |->
    ch_cnt_q[mv_ch_q] == (mv_cont_q ? mv_cnt_q : mv_cnt_q - `PIET_CNT_ONE))
    else $error("transfer count update wrong");
  a_done_int: assert property (@(posedge pclk) disable iff (!presetn)
    mv_valid_q && !mv_cont_q && mv_cnt_q == `PIET_CNT_ONE |->
    req_q[mv_sidx_q] && force_q[mv_sidx_q])
    else $error("count exhaustion did not request vector");
  a_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    eng_fire |=> mv_valid_q && (!req_q[$past(win_idx)] || $past(set_v[win_idx])))
    else $error("transfer not issued in one cycle");
endmodule : piet_ctrl
`default_nettype wire

// ===== bench/piet_cpu_model.sv
// CPU core model: accepts vector offers after a programmable delay
`default_nettype none
module piet_cpu_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        vec_req,
  input  wire logic [23:0] vec_addr,
  input  wire logic        vec_trap,
  input  wire logic [3:0]  ack_dly,
  output logic             cpu_ack,
  output logic [23:0]      last_addr,
  output logic             last_trap,
  output logic [7:0]       ack_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Ack only while an offer stands; one idle edge after each ack
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_ack   <= 1'b0;
      wait_q    <= 4'h0;
      last_addr <= 24'h000000;
      last_trap <= 1'b0;
      ack_cnt   <= 8'h00;
    end
    else if (cpu_ack)
    begin
      cpu_ack <= 1'b0;
      wait_q  <= 4'h0;
    end
    else if (vec_req && wait_q >= ack_dly)
    begin
      cpu_ack   <= 1'b1;
      last_addr <= vec_addr;
      last_trap <= vec_trap;
      ack_cnt   <= ack_cnt + 8'h01;
    end
    else if (vec_req)
    begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : piet_cpu_model
`default_nettype wire

// ===== bench/test_priority_interrupt_event_transfer.sv
// Self-checking bench for the interrupt controller and transfer engine
`default_nettype none
module test_priority_interrupt_event_transfer;
  timeunit 1ns;
  timeprecision 1ps;
  import piet_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0]  fast_pin, cpu_level, vec_level, ack_dly;
  logic [7:0]  hw_req, trap_num, ack_cnt, seen;
  logic        cpu_ack, trap_valid, vec_req, vec_trap, mv_valid, mv_word, irq, last_trap;
  logic [23:0] vec_addr, mv_src, mv_dst, last_addr;
  int          error_cnt, total_checks;
  piet_ctrl piet_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_pin(fast_pin), .hw_req(hw_req), .cpu_level(cpu_level),
    .cpu_ack(cpu_ack), .trap_valid(trap_valid), .trap_num(trap_num), .vec_req(vec_req),
    .vec_addr(vec_addr), .vec_level(vec_level), .vec_trap(vec_trap), .mv_valid(mv_valid),
    .mv_src(mv_src), .mv_dst(mv_dst), .mv_word(mv_word), .irq(irq));
  piet_cpu_model piet_cpu_model_i (.pclk(pclk), .presetn(presetn), .vec_req(vec_req),
    .vec_addr(vec_addr), .vec_trap(vec_trap), .ack_dly(ack_dly), .cpu_ack(cpu_ack),
    .last_addr(last_addr), .last_trap(last_trap), .ack_cnt(ack_cnt));
  always #12.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a stalled transfer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask : rd_chk
  task automatic pulse(input logic [7:0] m);
    @(posedge pclk);
    hw_req <= m;
    @(posedge pclk);
    hw_req <= 8'h00;
  endtask : pulse
  task automatic wait_ack(input logic [23:0] exp);
    int n;
    n = 0;
    while (ack_cnt === seen && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, ack_cnt !== seen}, 32'h1);
    seen = ack_cnt;
    chk({8'h00, last_addr}, {8'h00, exp});
  endtask : wait_ack
  task automatic wait_mv(input logic [23:0] s, input logic [23:0] d, input logic w);
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (mv_valid !== 1'b1 && n < 20);
    chk({31'h0, mv_valid}, 32'h1);
    chk({8'h00, mv_src}, {8'h00, s});
    chk({8'h00, mv_dst}, {8'h00, d});
    chk({31'h0, mv_word}, {31'h0, w});
    chk({31'h0, vec_req}, 32'h0);
  endtask : wait_mv
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk(12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h000000FF);
    rd_chk(12'h000, 32'h000000FF);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h174, 32'h00123456);
    rd_chk(12'h174, 32'h00123456);
    rd_chk(12'h204, 32'h0);
    apb(1'b0, 12'h300, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    chk(rd_q, 32'h0);
  endtask : t_regs
  task automatic t_vec;
    int n;
    n = 0;
    apb(1'b1, 12'h20C, 32'h1);
    apb(1'b1, 12'h008, 32'h105);
    pulse(8'h04);
    while (vec_req !== 1'b1 && n < 12)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, vec_req}, 32'h1);
    wait_ack(24'h000068);
    cyc(2);
    rd_chk(12'h008, 32'h105);
    rd_chk(12'h204, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h20C, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h20C, 32'h1);
    apb(1'b1, 12'h208, 32'h7);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
  endtask : t_vec
  task automatic t_prio;
    ack_dly   <= 4'h3;
    cpu_level <= 4'hF;
    apb(1'b1, 12'h004, 32'h303);
    apb(1'b1, 12'h00C, 32'h309);
    apb(1'b1, 12'h010, 32'h306);
    apb(1'b1, 12'h014, 32'h306);
    cyc(4);
    chk({31'h0, vec_req}, 32'h0);
    cpu_level <= 4'h9;
    cyc(4);
    chk({31'h0, vec_req}, 32'h0);
    cpu_level <= 4'h0;
    wait_ack(24'h00006C);
    chk({28'h0, vec_level}, 32'h9);
    wait_ack(24'h000070);
    wait_ack(24'h000074);
    wait_ack(24'h000064);
  endtask : t_prio
  task automatic t_trap;
    @(posedge pclk);
    trap_valid <= 1'b1;
    trap_num   <= 8'h2A;
    @(posedge pclk);
    trap_valid <= 1'b0;
    wait_ack(24'h0000A8);
    chk({31'h0, last_trap}, 32'h1);
  endtask : t_trap
  // Off, both, fall and rise modes on inputs 3..0
  task automatic t_fast;
    logic [3:0] exp [2];
    exp = '{4'b0101, 4'b0110};
    for (int i = 0; i < 4; i++) apb(1'b1, 12'(4 * i), 32'h0);
    apb(1'b1, 12'h200, 32'h39);
    for (int p = 0; p < 2; p++)
    begin
      fast_pin <= (p == 0) ? 4'hF : 4'h0;
      cyc(4);
      for (int i = 0; i < 4; i++)
      begin
        apb(1'b0, 12'(4 * i), 32'h0);
        chk({31'h0, rd_q[9]}, {31'h0, exp[p][i]});
        apb(1'b1, 12'(4 * i), 32'h0);
      end
    end
  endtask : t_fast
  task automatic t_xfer;
    ack_dly <= 4'h2;
    apb(1'b1, 12'h100, 32'h002);
    apb(1'b1, 12'h104, 32'h1000);
    apb(1'b1, 12'h108, 32'h2000);
    apb(1'b1, 12'h170, 32'h703);
    apb(1'b1, 12'h174, 32'h4000);
    apb(1'b1, 12'h178, 32'h3000);
    apb(1'b1, 12'h018, 32'h184);
    apb(1'b1, 12'h01C, 32'h1F4);
    pulse(8'h40);
    wait_mv(24'h001000, 24'h002000, 1'b0);
    rd_chk(12'h100, 32'h001);
    pulse(8'h40);
    wait_mv(24'h001001, 24'h002000, 1'b0);
    wait_ack(24'h000078);
    rd_chk(12'h100, 32'h000);
    pulse(8'h80);
    wait_mv(24'h004000, 24'h003000, 1'b1);
    rd_chk(12'h170, 32'h703);
    rd_chk(12'h178, 32'h3002);
    rd_chk(12'h204, 32'h7);
  endtask : t_xfer
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // Whole run needs a few hundred cycles
  initial
  begin
    #(25 * 20000);
    error_cnt++;
    results();
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fast_pin, hw_req, cpu_level, trap_valid, trap_num, ack_dly, seen} = '0;
    error_cnt    = 0;
    total_checks = 0;
    cyc(6);
    presetn <= 1'b1;
    t_regs();
    t_vec();
    t_prio();
    t_trap();
    t_fast();
    t_xfer();
    results();
  end
endmodule : test_priority_interrupt_event_transfer
`default_nettype wire
